// ---- core/serial_port_pkg.sv ----
// Constants shared by the serial host register port.
// Assumes a 250 MHz core clock and a host-driven shift clock.
package serial_port_pkg;
  // ----------------------------------------------------------------
  // Frame layout (counts of shift-clock rising edges already seen)
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_DIR = 5'h00;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h06;
  localparam logic [4:0] CNT_PAD = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0F;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  localparam logic [4:0] CNT_OVERRUN = 5'h11;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] ADDR_RST = 6'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_MIN_NS = 10;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- core/pin_sync.sv ----
// Two-stage synchroniser for the three host pins.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] pin_i,
  output logic [2:0] pin_o
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // Select idles high, clock and data idle low
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{s1: 3'h4, s2: 3'h4};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_o = st_r.s2;
endmodule

// ---- core/serial_host_port.sv ----
// Serial host register port: 16-bit frames in, register strobes out.
// Assumes the register file sits on clk_i and answers rd_addr_o
// within a few cycles; host pins are asynchronous.
`timescale 1ns/1ns
// Notes on behaviour
// - A frame is exactly sixteen bits
// - Input sampled on shift clock rising edges
// - Write commits only at select high
// - Output changes only on falling edges
// - First bit: zero writes, one reads
// - Bits two to seven: index, LSB first
// - Eighth bit is ignored padding
// - Bits nine to sixteen: write data
// - Read bit zero out at fall eight
// - Output released after eight read bits
// - Reset low restores all defaults
// - Active-low attention output for events
module serial_host_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_o,
  output logic wr_en_o,
  output logic [5:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [5:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic event_i,
  output logic attn_n_o
);
  typedef struct packed {
    logic [4:0] cnt;
    logic dir;
    logic [5:0] addr;
    logic [7:0] data;
    logic sclk_prev;
    logic sel_prev;
    logic [7:0] out_sh;
    logic out;
    logic oe;
    logic wr_en;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [5:0] rd_addr;
    logic attn_n;
  } port_t;

  port_t st_r;
  port_t st_nxt;
  logic [2:0] pins_s;
  logic sel_n_s;
  logic sclk_s;
  logic sin_s;
  logic rise_w;
  logic fall_w;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({sel_n_i, sclk_i, serial_in_line_i}),
    .pin_o(pins_s)
  );

  assign sel_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sin_s = pins_s[0];
  // Edges found by the core clock; shift clock is far slower
  assign rise_w = sclk_s & ~st_r.sclk_prev;
  assign fall_w = ~sclk_s & st_r.sclk_prev;

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_en = 1'h0;
    st_nxt.sclk_prev = sclk_s;
    st_nxt.sel_prev = sel_n_s;
    st_nxt.attn_n = ~event_i;
    if (sel_n_s) begin
      st_nxt.cnt = serial_port_pkg::CNT_DIR;
      st_nxt.oe = 1'h0;
      if (!st_r.sel_prev && st_r.cnt == serial_port_pkg::CNT_FRAME &&
          st_r.dir == serial_port_pkg::DIR_WRITE) begin
        st_nxt.wr_en = 1'h1;
        st_nxt.wr_addr = st_r.addr;
        st_nxt.wr_data = st_r.data;
      end
    end else begin
      if (rise_w && st_r.cnt != serial_port_pkg::CNT_OVERRUN) begin
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == serial_port_pkg::CNT_DIR) begin
          st_nxt.dir = sin_s;
        end else if (st_r.cnt <= serial_port_pkg::CNT_ADDR_LAST) begin
          st_nxt.addr[st_r.cnt[2:0] - 3'h1] = sin_s;
          if (st_r.cnt == serial_port_pkg::CNT_ADDR_LAST) begin
            st_nxt.rd_addr = {sin_s, st_r.addr[4:0]};
          end
        end else if (st_r.cnt >= serial_port_pkg::CNT_DATA_FIRST &&
                     st_r.cnt <= serial_port_pkg::CNT_DATA_LAST) begin
          st_nxt.data[st_r.cnt[2:0]] = sin_s;
        end
      end
      if (fall_w && st_r.dir == serial_port_pkg::DIR_READ) begin
        if (st_r.cnt == serial_port_pkg::CNT_DATA_FIRST) begin
          st_nxt.out_sh = rd_data_i;
          st_nxt.out = rd_data_i[0];
          st_nxt.oe = 1'h1;
        end else if (st_r.cnt > serial_port_pkg::CNT_DATA_FIRST &&
                     st_r.cnt <= serial_port_pkg::CNT_DATA_LAST) begin
          st_nxt.out = st_r.out_sh[st_r.cnt[2:0]];
        end else if (st_r.cnt >= serial_port_pkg::CNT_FRAME) begin
          st_nxt.oe = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{cnt: 5'h00, dir: 1'h0,
                addr: serial_port_pkg::ADDR_RST,
                data: serial_port_pkg::DATA_RST,
                sclk_prev: 1'h0, sel_prev: 1'h1,
                out_sh: serial_port_pkg::DATA_RST, out: 1'h0, oe: 1'h0,
                wr_en: 1'h0, wr_addr: serial_port_pkg::ADDR_RST,
                wr_data: serial_port_pkg::DATA_RST,
                rd_addr: serial_port_pkg::ADDR_RST, attn_n: 1'h1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serial_out_line_o = st_r.out;
  assign serial_out_line_oe_o = st_r.oe;
  assign wr_en_o = st_r.wr_en;
  assign wr_addr_o = st_r.wr_addr;
  assign wr_data_o = st_r.wr_data;
  assign rd_addr_o = st_r.rd_addr;
  assign attn_n_o = st_r.attn_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_full_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.wr_en |-> $past(st_r.cnt) == 5'h10 && $past(st_r.dir) == 1'h0)
    else $error("write without full frame");
  a_count_bounded: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.cnt <= 5'h11) else $error("bit count beyond overrun");
  a_select_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sel_n_s |=> st_r.cnt == 5'h00 && !st_r.oe)
    else $error("count not cleared");
  a_dir_sampled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sel_n_s && rise_w && st_r.cnt == 5'h00 |=> st_r.dir == $past(sin_s))
    else $error("direction not sampled");
  a_addr_lsb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sel_n_s && rise_w && st_r.cnt == 5'h01 |=> st_r.addr[0] == $past(sin_s))
    else $error("index bit zero wrong");
  a_pad_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sel_n_s && rise_w && st_r.cnt == 5'h07
      |=> $stable(st_r.addr) && $stable(st_r.data))
    else $error("pad bit stored");
  a_data_lsb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sel_n_s && rise_w && st_r.cnt == 5'h08 |=> st_r.data[0] == $past(sin_s))
    else $error("data bit zero wrong");
  a_out_on_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(serial_out_line_o) |-> $past(fall_w))
    else $error("output moved off a fall");
  a_first_read_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sel_n_s && fall_w && st_r.dir && st_r.cnt == 5'h08
      |=> serial_out_line_oe_o && serial_out_line_o == $past(rd_data_i[0]))
    else $error("read bit zero missing");
  a_release_after: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fall_w && st_r.cnt >= 5'h10 |=> !serial_out_line_oe_o)
    else $error("output not released");
  a_attn_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    event_i |=> !attn_n_o) else $error("attention not raised");
endmodule

// ---- sim/host_side.sv ----
// Host model: drives select, shift clock and serial input.
// Assumes the bench clock clk_i; pins change on its falling edge.
`timescale 1ns/1ns
module host_side (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic oe_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  logic [7:0] rd_q;
  logic oe_end;
  initial begin
    sel_n_o = 1'h1;
    sclk_o = 1'h0;
    sdi_o = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // ---------------------------------------------
  // One frame of nb shift clocks, 124 ns period
  // ---------------------------------------------
  task automatic frame(input logic dir, input logic [5:0] a,
                       input logic [7:0] d, input int nb);
    logic [15:0] f;
    f = {d, 1'h1, a, dir};
    sel_n_o = 1'h0;
    tick(4);
    for (int i = 0; i < nb; i++) begin
      sdi_o = f[i % 16];
      tick(15);
      if (i >= 8 && i < 16) rd_q[i - 8] = sdo_i;
      sclk_o = 1'h1;
      tick(16);
      sclk_o = 1'h0;
      // Stale data line: show the inverse, never the last bit
      sdi_o = ~sdi_o;
    end
    tick(8);
    oe_end = oe_i;
    sel_n_o = 1'h1;
    tick(8);
  endtask
endmodule

// ---- sim/serial_host_port_tb.sv ----
// Bench for the serial host port with a small register array.
// Assumes host_side as the far side; no outside stimulus files.
`timescale 1ns/1ns
module serial_host_port_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ev = 1'h0;
  logic sel_n, sclk, serial_in_line, serial_out_line, oe, wr_en, attn_n;
  logic [5:0] wa, ra;
  logic [7:0] wd, rd;
  logic [7:0] mem [64];
  int mismatches = 0;
  int compares = 0;
  int nwr = 0;
  always #2 clk = ~clk;
  assign rd = mem[ra];
  serial_host_port DUT (.clk_i(clk), .rst_n_i(rst_n), .sel_n_i(sel_n),
    .sclk_i(sclk), .serial_in_line_i(serial_in_line), .serial_out_line_o(serial_out_line),
    .serial_out_line_oe_o(oe), .wr_en_o(wr_en), .wr_addr_o(wa),
    .wr_data_o(wd), .rd_addr_o(ra), .rd_data_i(rd), .event_i(ev),
    .attn_n_o(attn_n));
  host_side host (.clk_i(clk), .sdo_i(serial_out_line), .oe_i(oe), .sel_n_o(sel_n),
    .sclk_o(sclk), .sdi_o(serial_in_line));
  always @(posedge clk) begin
    if (wr_en === 1'h1) begin
      mem[wa] <= wd;
      nwr <= nwr + 1;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(serial_out_line) begin
    if (sclk === 1'h1 && oe === 1'h1) begin
      mismatches++;
      $display("MISMATCH %0t output moved with clock high", $time);
    end
  end
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_write_read;
    logic [5:0] a [2] = '{6'h2A, 6'h15};
    logic [7:0] d [2] = '{8'hC5, 8'h3A};
    int n;
    for (int k = 0; k < 2; k++) begin
      n = nwr;
      host.frame(1'h0, a[k], d[k], 16);
      chk(8'(nwr - n), 8'h01);
      n = nwr;
      host.frame(1'h1, a[k], 8'hFF, 16);
      chk(8'(nwr - n), 8'h00);
      chk(host.rd_q, d[k]);
      chk({7'h00, host.oe_end}, 8'h00);
    end
    $display("test write_read done");
  endtask
  task automatic t_bad_len;
    int n;
    n = nwr;
    host.frame(1'h0, 6'h01, 8'hFF, 15);
    host.frame(1'h0, 6'h01, 8'hFF, 17);
    chk(8'(nwr - n), 8'h00);
    chk(mem[1], 8'h00);
    $display("test bad_len done");
  endtask
  task automatic t_attn;
    ev = 1'h1;
    repeat (2) @(negedge clk);
    chk({7'h00, attn_n}, 8'h00);
    ev = 1'h0;
    repeat (2) @(negedge clk);
    chk({7'h00, attn_n}, 8'h01);
    $display("test attn done");
  endtask
  task automatic t_reset;
    int n;
    n = nwr;
    fork
      host.frame(1'h0, 6'h05, 8'h77, 16);
      begin
        repeat (300) @(negedge clk);
        rst_n = 1'h0;
        repeat (3) @(negedge clk);
        chk({ra, oe, wr_en}, 8'h00);
        rst_n = 1'h1;
      end
    join
    chk(8'(nwr - n), 8'h00);
    $display("test reset done");
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard well past the longest run
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    t_write_read();
    t_bad_len();
    t_attn();
    t_reset();
    give_verdict();
  end
endmodule
